// file: hdl/sds_cmd_unit.sv
// Status and acceleration read command decoder with Avalon-MM registers
//
// Notes on behaviour
// - Status request works in all four formats
// - Acceleration read works in all four formats
// - Enhanced formats only once enabled beforehand
// - Global address zero ignores both requests
// - Request data byte only feeds CRC
// - Address mismatch ignores the request
// - Status request code is 0001
// - Acceleration read code is 0010
// - Short status: flags in low byte
// - Long status: address on top nibble
// - Error flag shows internal error
// - Self-test flag shows self-test active
// - Undervoltage flag follows reservoir monitor
// - OTP flag shows programming enabled
// - Attribute bits from configuration register
// - Reply sized to received message length
// - Long acceleration: address, zero, error, data
// - Truncated zero result sends minimum
// - Offset binary, code zero means error
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module sds_cmd_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Decoded request frame
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_addr,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_long,
  input wire logic cmd_enhanced,
  input wire logic [sds_pkg::SDS_LEN_W-1:0] cmd_len,
  // Device state
  input wire logic internal_error,
  input wire logic selftest_active,
  input wire logic reservoir_cap_node_low,
  input wire logic otp_prog_enable,
  input wire logic [9:0] accel_result,
  // Reply
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [sds_pkg::SDS_LEN_W-1:0] rsp_len,
  output logic rsp_is_accel
);
  import sds_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] device_config_reg_one_r;
  logic [31:0] readdata_r;
  logic waitrequest_r;
  logic [15:0] reply_cnt_r;
  logic [15:0] ignore_cnt_r;
  logic [3:0] last_code_r;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;
  logic [SDS_LEN_W-1:0] rsp_len_r;
  logic rsp_is_accel_r;

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire logic [3:0] own_addr;
  wire logic enh_enable;
  wire logic [1:0] attribute_bits;
  wire logic bus_req;
  wire logic bus_ack;
  wire logic ctrl_wr;
  wire logic [31:0] status_view;
  wire logic [31:0] rd_mux;

  assign own_addr = device_config_reg_one_r[SDS_CTRL_ADDR_LSB +: 4];
  assign enh_enable = device_config_reg_one_r[SDS_CTRL_ENH_BIT];
  assign attribute_bits = device_config_reg_one_r[SDS_CTRL_AT_LSB +: 2];

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire logic addr_ok;
  wire logic fmt_ok;
  wire logic len_ok;
  wire logic is_status;
  wire logic is_accel;
  wire logic accept;
  wire logic ignore;
  wire logic [SDS_LEN_W-1:0] reply_len;
  wire logic [15:0] reply_word;

  assign addr_ok = (own_addr != SDS_GLOBAL_ADDR) && (cmd_addr == own_addr);
  assign fmt_ok = !cmd_enhanced || enh_enable;
  assign len_ok = cmd_long || (cmd_len >= SDS_MIN_SHORT_LEN);
  assign is_status = (cmd_code == SDS_CMD_STATUS);
  assign is_accel = (cmd_code == SDS_CMD_ACCEL);
  assign accept = cmd_valid && addr_ok && fmt_ok && len_ok && (is_status || is_accel);
  assign ignore = cmd_valid && !accept;
  assign reply_len = cmd_long ? SDS_LONG_LEN : cmd_len;

  sds_reply_fmt sds_reply_fmt_inst (
    .is_accel(is_accel),
    .is_long(cmd_long),
    .reply_len(reply_len),
    .dev_addr(own_addr),
    .err_flag(internal_error),
    .selftest_active_flag(selftest_active),
    .uv_flag(reservoir_cap_node_low),
    .otp_prog_enable_flag(otp_prog_enable),
    .attribute_bits(attribute_bits),
    .accel_raw(accel_result),
    .reply_word(reply_word)
  );

  // ----------------------------------------
  // Reply registers
  // ----------------------------------------
  // no reply for ignored requests
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
      rsp_len_r <= '0;
      rsp_is_accel_r <= 1'b0;
    end else begin
      rsp_valid_r <= accept;
      if (accept) begin
        rsp_data_r <= reply_word;
        rsp_len_r <= reply_len;
        rsp_is_accel_r <= is_accel;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reply_cnt_r <= 16'h0000;
      ignore_cnt_r <= 16'h0000;
      last_code_r <= 4'h0;
    end else begin
      if (accept) begin
        reply_cnt_r <= reply_cnt_r + 16'h0001;
        last_code_r <= cmd_code;
      end
      if (ignore) begin
        ignore_cnt_r <= ignore_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  assign bus_req = avs_read || avs_write;
  assign bus_ack = bus_req && !waitrequest_r;
  assign ctrl_wr = avs_write && !waitrequest_r && (avs_address == SDS_REG_CTRL) && avs_byteenable[0];
  assign status_view = {24'h00_0000, last_code_r, otp_prog_enable, reservoir_cap_node_low,
                        selftest_active, internal_error};
  assign rd_mux = (avs_address == SDS_REG_CTRL) ? device_config_reg_one_r :
                  (avs_address == SDS_REG_STATUS) ? status_view :
                  (avs_address == SDS_REG_COUNT) ? {ignore_cnt_r, reply_cnt_r} : 32'h0000_0000;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitrequest_r <= !(bus_req && waitrequest_r);
      if (avs_read && waitrequest_r) begin
        readdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      device_config_reg_one_r <= SDS_CTRL_RST;
    end else if (ctrl_wr) begin
      device_config_reg_one_r <= {25'h000_0000, avs_writedata[6:0]};
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_len = rsp_len_r;
  assign rsp_is_accel = rsp_is_accel_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_hit;
    cmd_valid && addr_ok && fmt_ok && len_ok;
  endsequence
  sequence s_status_req;
    s_hit ##0 (cmd_code == 4'h1);
  endsequence
  sequence s_accel_req;
    s_hit ##0 (cmd_code == 4'h2);
  endsequence

  property p_global_ignored;
    cmd_valid && own_addr == 4'h0 |=> !rsp_valid;
  endproperty
  a_global_ignored: assert property (p_global_ignored) else $error("reply at global address");

  property p_mismatch_silent;
    cmd_valid && cmd_addr != own_addr |=> !rsp_valid;
  endproperty
  a_mismatch_silent: assert property (p_mismatch_silent) else $error("reply to foreign address");

  property p_status_reply;
    s_status_req |=> rsp_valid && !rsp_is_accel && rsp_len == $past(reply_len);
  endproperty
  a_status_reply: assert property (p_status_reply) else $error("status request not answered");

  property p_accel_reply;
    s_accel_req |=> rsp_valid && rsp_is_accel;
  endproperty
  a_accel_reply: assert property (p_accel_reply) else $error("acceleration request not answered");

  property p_enh_gated;
    cmd_valid && cmd_enhanced && !enh_enable |=> !rsp_valid;
  endproperty
  a_enh_gated: assert property (p_enh_gated) else $error("enhanced frame answered while disabled");

  property p_short_status_top;
    rsp_valid && !rsp_is_accel && rsp_len != 5'h10 |-> rsp_data[15:8] == 8'h00 && rsp_data[4] == 1'b0;
  endproperty
  a_short_status_top: assert property (p_short_status_top) else $error("short status upper bits set");

  property p_long_addr;
    (s_hit ##0 (cmd_long && (is_status || is_accel))) |=> rsp_data[15:12] == $past(cmd_addr) && rsp_data[11] == 1'b0;
  endproperty
  a_long_addr: assert property (p_long_addr) else $error("long reply address wrong");

  property p_status_err;
    s_status_req |=> rsp_data[1] == $past(internal_error) && rsp_data[5] == $past(selftest_active);
  endproperty
  a_status_err: assert property (p_status_err) else $error("status flags wrong");

  property p_accel_nonzero;
    s_accel_req ##0 !internal_error |=> rsp_data != 16'h0000;
  endproperty
  a_accel_nonzero: assert property (p_accel_nonzero) else $error("error code sent without error");

  property p_len_mask;
    rsp_valid && rsp_len < 5'h10 |-> (rsp_data >> rsp_len) == 16'h0000;
  endproperty
  a_len_mask: assert property (p_len_mask) else $error("reply longer than message");

  property p_bus_answer;
    bus_req && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

  property p_accel_long_err;
    s_accel_req ##0 cmd_long |=> rsp_data[10] == $past(internal_error) && rsp_data[11] == 1'b0;
  endproperty
  a_accel_long_err: assert property (p_accel_long_err) else $error("long acceleration error bit wrong");

  property p_err_code;
    s_accel_req ##0 (cmd_long && internal_error) |=> rsp_data[9:0] == SDS_ACCEL_ERR;
  endproperty
  a_err_code: assert property (p_err_code) else $error("error code missing on sensor error");

  property p_uv_flag;
    s_status_req |=> rsp_data[6] == $past(reservoir_cap_node_low);
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag wrong");

  property p_otp_flag;
    s_status_req |=> rsp_data[7] == $past(otp_prog_enable);
  endproperty
  a_otp_flag: assert property (p_otp_flag) else $error("otp enable flag wrong");

  property p_attr_bits;
    s_status_req |=> rsp_data[3:2] == $past(attribute_bits);
  endproperty
  a_attr_bits: assert property (p_attr_bits) else $error("attribute bits wrong");

  property p_code_ignored;
    cmd_valid && !is_status && !is_accel |=> !rsp_valid;
  endproperty
  a_code_ignored: assert property (p_code_ignored) else $error("reply to unknown command");
endmodule

// file: hdl/sds_pkg.sv
// Constants and types for the status and acceleration read command block
package sds_pkg;
  // ----------------------------------------
  // Command codes and addressing
  // ----------------------------------------
  localparam logic [3:0] SDS_CMD_STATUS = 4'h1;
  localparam logic [3:0] SDS_CMD_ACCEL = 4'h2;
  localparam logic [3:0] SDS_GLOBAL_ADDR = 4'h0;
  // ----------------------------------------
  // Reply lengths
  // ----------------------------------------
  localparam int SDS_LEN_W = 5;
  localparam logic [4:0] SDS_LONG_LEN = 5'h10;
  localparam logic [4:0] SDS_MIN_SHORT_LEN = 5'h08;
  localparam logic [4:0] SDS_LEN_NINE = 5'h09;
  // ----------------------------------------
  // Acceleration codes
  // ----------------------------------------
  localparam logic [9:0] SDS_ACCEL_ERR = 10'h000;
  localparam logic [9:0] SDS_ACCEL_MIN = 10'h001;
  localparam logic [9:0] SDS_ACCEL_ZERO_G = 10'h200;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] SDS_REG_CTRL = 4'h0;
  localparam logic [3:0] SDS_REG_STATUS = 4'h4;
  localparam logic [3:0] SDS_REG_COUNT = 4'h8;
  localparam logic [31:0] SDS_CTRL_RST = 32'h0000_0000;
  localparam int SDS_CTRL_ADDR_LSB = 0;
  localparam int SDS_CTRL_ENH_BIT = 4;
  localparam int SDS_CTRL_AT_LSB = 5;
  localparam int SDS_ST_ERR_BIT = 0;
  localparam int SDS_ST_SELFTEST_BIT = 1;
  localparam int SDS_ST_UV_BIT = 2;
  localparam int SDS_ST_OTP_BIT = 3;
  localparam int SDS_ST_CODE_LSB = 4;
  localparam int SDS_CNT_IGN_LSB = 16;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {SDS_KIND_NONE, SDS_KIND_STATUS, SDS_KIND_ACCEL} sds_kind_t;
endpackage

// file: hdl/sds_reply_fmt.sv
// Reply word builder for status and acceleration replies
`timescale 1ns/100ps
module sds_reply_fmt (
  // Request shape
  input wire logic is_accel,
  input wire logic is_long,
  input wire logic [sds_pkg::SDS_LEN_W-1:0] reply_len,
  input wire logic [3:0] dev_addr,
  // Reported state
  input wire logic err_flag,
  input wire logic selftest_active_flag,
  input wire logic uv_flag,
  input wire logic otp_prog_enable_flag,
  input wire logic [1:0] attribute_bits,
  input wire logic [9:0] accel_raw,
  // Result
  output logic [15:0] reply_word
);
  import sds_pkg::*;

  // ----------------------------------------
  // Status layout
  // ----------------------------------------
  wire logic [7:0] status_low;
  wire logic [15:0] status_word;
  wire logic [9:0] accel_code;
  wire logic [7:0] accel8;
  wire logic [8:0] accel9;
  wire logic [15:0] accel_short;
  wire logic [15:0] accel_word;
  wire logic [15:0] raw_word;
  wire logic [15:0] len_mask;

  assign status_low = {otp_prog_enable_flag, uv_flag, selftest_active_flag, 1'b0, attribute_bits, err_flag, 1'b0};
  assign status_word = is_long ? {dev_addr, 4'h0, status_low} : {8'h00, status_low};

  // ----------------------------------------
  // Acceleration layout
  // ----------------------------------------
  // zero code reserved for errors
  assign accel_code = err_flag ? SDS_ACCEL_ERR : ((accel_raw == SDS_ACCEL_ERR) ? SDS_ACCEL_MIN : accel_raw);
  assign accel8 = (err_flag || accel_code[9:2] != 8'h00) ? accel_code[9:2] : SDS_ACCEL_MIN[7:0];
  assign accel9 = (err_flag || accel_code[9:1] != 9'h000) ? accel_code[9:1] : SDS_ACCEL_MIN[8:0];
  assign accel_short = (reply_len == SDS_MIN_SHORT_LEN) ? {8'h00, accel8} :
                       (reply_len == SDS_LEN_NINE) ? {7'h00, accel9} :
                       {1'b0, attribute_bits, selftest_active_flag, 1'b0, err_flag, accel_code};
  assign accel_word = is_long ? {dev_addr, 1'b0, err_flag, accel_code} : accel_short;
  assign raw_word = is_accel ? accel_word : status_word;

  // ----------------------------------------
  // Length mask
  // ----------------------------------------
  // bits beyond length stay zero
  for (genvar i = 0; i < 16; i++) begin : g_mask
    assign len_mask[i] = is_long || (5'(i) < reply_len);
  end
  assign reply_word = raw_word & len_mask;
endmodule

// file: test/sds_master_model.sv
// Frame source standing in for the satellite bus master
`timescale 1ns/100ps
module sds_master_model (
  // Clock
  input wire logic ref_clk,
  // Decoded request frame
  output logic cmd_valid,
  output logic [3:0] cmd_addr,
  output logic [3:0] cmd_code,
  output logic cmd_long,
  output logic cmd_enhanced,
  output logic [sds_pkg::SDS_LEN_W-1:0] cmd_len
);
  import sds_pkg::*;
  initial begin
    {cmd_valid, cmd_addr, cmd_code, cmd_long, cmd_enhanced, cmd_len} = '0;
  end
  task automatic send(input logic [3:0] a, input logic [3:0] c, input logic lg, input logic en,
    input logic [4:0] ln);
    @(posedge ref_clk);
    {cmd_valid, cmd_addr, cmd_code, cmd_long, cmd_enhanced, cmd_len} <= {1'b1, a, c, lg, en, ln};
    @(posedge ref_clk);
    // Released fields go inverted
    {cmd_valid, cmd_addr, cmd_code, cmd_long, cmd_enhanced, cmd_len} <= {1'b0, ~a, ~c, ~lg, ~en, ~ln};
  endtask
endmodule

// file: test/sensor_status_and_accel_read_cmds_tb_top.sv
// Self-checking bench for the command unit
`timescale 1ns/100ps
module sensor_status_and_accel_read_cmds_tb_top;
  import sds_pkg::*;
  logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, rsp_valid, rsp_is_accel;
  logic [3:0] avs_address, own;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic cmd_valid, cmd_long, cmd_enhanced;
  logic [3:0] cmd_addr, cmd_code;
  logic [4:0] cmd_len, rsp_len;
  logic internal_error, selftest_active, reservoir_cap_node_low, otp_prog_enable;
  logic [1:0] at;
  logic [9:0] accel_result;
  logic [15:0] rsp_data, rep_n, ign_n;
  int error_cnt, num_checks;
  sds_cmd_unit sds_cmd_unit_inst (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_code(cmd_code), .cmd_long(cmd_long), .cmd_enhanced(cmd_enhanced),
    .cmd_len(cmd_len), .internal_error(internal_error), .selftest_active(selftest_active),
    .reservoir_cap_node_low(reservoir_cap_node_low), .otp_prog_enable(otp_prog_enable),
    .accel_result(accel_result), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_len(rsp_len),
    .rsp_is_accel(rsp_is_accel));
  sds_master_model sds_master_model_inst (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
    .cmd_code(cmd_code), .cmd_long(cmd_long), .cmd_enhanced(cmd_enhanced), .cmd_len(cmd_len));
  always #50 ref_clk = ~ref_clk;
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] exp_word(input logic acc, input logic lg, input logic [4:0] ln);
    logic [9:0] c;
    logic [15:0] w;
    c = internal_error ? SDS_ACCEL_ERR : (accel_result == SDS_ACCEL_ERR ? SDS_ACCEL_MIN : accel_result);
    if (!acc) w = {(lg ? {own, 4'h0} : 8'h00), otp_prog_enable, reservoir_cap_node_low, selftest_active, 1'b0,
      at, internal_error, 1'b0};
    else if (lg) w = {own, 1'b0, internal_error, c};
    else if (ln == 5'h08) w = {8'h00, (c[9:2] == 8'h00 && !internal_error) ? 8'h01 : c[9:2]};
    else if (ln == 5'h09) w = {7'h00, (c[9:1] == 9'h000 && !internal_error) ? 9'h001 : c[9:1]};
    else w = {1'b0, at, selftest_active, 1'b0, internal_error, c};
    if (!lg) w = w & ((16'h0001 << ln) - 16'h0001);
    return w;
  endfunction
  // ----------------------------------------
  // Bus and frame tasks
  // ----------------------------------------
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) error_cnt++;
  endtask
  task automatic req(input logic [3:0] a, input logic [3:0] c, input logic lg, input logic en,
    input logic [4:0] ln, input logic ok);
    logic [4:0] el;
    sds_master_model_inst.send(a, c, lg, en, ln);
    #1;
    el = lg ? SDS_LONG_LEN : ln;
    chk(rsp_valid, ok);
    if (ok) begin
      chk(rsp_data, exp_word(c == SDS_CMD_ACCEL, lg, el));
      chk(rsp_len, el);
      chk(rsp_is_accel, c == SDS_CMD_ACCEL);
      rep_n++;
    end
    else ign_n++;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {ref_clk, nrst, avs_read, avs_write, avs_address, avs_writedata, rep_n, ign_n} = '0;
    {internal_error, selftest_active, reservoir_cap_node_low, otp_prog_enable, own, at} = '0;
    accel_result = SDS_ACCEL_ZERO_G;
    avs_byteenable = 4'hF;
    {error_cnt, num_checks} = '0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    bus_xfer(1'b0, SDS_REG_CTRL, 32'h0);
    chk(q, SDS_CTRL_RST);
    req(4'h0, SDS_CMD_STATUS, 1'b1, 1'b0, 5'h10, 1'b0);
    own = 4'h5;
    at = 2'b10;
    bus_xfer(1'b1, SDS_REG_CTRL, {25'h0, at, 1'b0, own});
    // Write with lane zero off leaves configuration
    @(posedge ref_clk);
    avs_byteenable <= 4'hE;
    bus_xfer(1'b1, SDS_REG_CTRL, 32'h0000_007F);
    avs_byteenable <= 4'hF;
    bus_xfer(1'b0, SDS_REG_CTRL, 32'h0);
    chk(q, {25'h0, at, 1'b0, own});
    bus_xfer(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0000_0000);
    req(own, SDS_CMD_STATUS, 1'b1, 1'b1, 5'h10, 1'b0);
    bus_xfer(1'b1, SDS_REG_CTRL, {25'h0, at, 1'b1, own});
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      {internal_error, selftest_active, reservoir_cap_node_low, otp_prog_enable} <= p ? 4'hA : 4'h5;
      accel_result <= p ? 10'h2A7 : 10'h15C;
      bus_xfer(1'b0, SDS_REG_STATUS, 32'h0);
      chk(q[3:0], {otp_prog_enable, reservoir_cap_node_low, selftest_active, internal_error});
      chk(q[7:4], p ? SDS_CMD_ACCEL : 4'h0);
      for (int l = 8; l <= 16; l++) begin
        req(own, SDS_CMD_STATUS, l == 16, p[0], 5'(l), 1'b1);
        req(own, SDS_CMD_ACCEL, l == 16, p[0], 5'(l), 1'b1);
      end
    end
    req(4'h6, SDS_CMD_STATUS, 1'b1, 1'b0, 5'h10, 1'b0);
    req(own, 4'h3, 1'b1, 1'b0, 5'h10, 1'b0);
    @(posedge ref_clk);
    internal_error <= 1'b0;
    accel_result <= 10'h003;
    req(own, SDS_CMD_ACCEL, 1'b0, 1'b0, 5'h08, 1'b1);
    @(posedge ref_clk);
    accel_result <= SDS_ACCEL_ERR;
    req(own, SDS_CMD_ACCEL, 1'b1, 1'b0, 5'h10, 1'b1);
    @(posedge ref_clk);
    internal_error <= 1'b1;
    accel_result <= 10'h3FF;
    req(own, SDS_CMD_ACCEL, 1'b0, 1'b0, 5'h09, 1'b1);
    bus_xfer(1'b0, SDS_REG_COUNT, 32'h0);
    chk(q, {ign_n, rep_n});
    // Mid-run reset clears replies, address and counts
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(avs_waitrequest, 1'b1);
    chk(avs_readdata, 32'h0000_0000);
    chk({rsp_valid, rsp_is_accel, rsp_len, rsp_data}, 23'h00_0000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    req(own, SDS_CMD_STATUS, 1'b1, 1'b0, 5'h10, 1'b0);
    bus_xfer(1'b0, SDS_REG_COUNT, 32'h0);
    chk(q, 32'h0001_0000);
    report_and_stop;
  end
  initial begin
    #500_000;
    error_cnt++;
    report_and_stop;
  end
endmodule
